/* File: verification/test_oie_bank.sv */
// test_oie_bank.sv - self-checking bench for the oscillator interrupt enable bank.
// assumes: oie_cfg.svh on the include path, oie_pkg compiled first; bench drives all ports.
`timescale 1ns/1ps
`include "oie_cfg.svh"

module test_oie_bank;
    import oie_pkg::*;
    logic       clk_i, rst_b_i, set_wr_i, clr_wr_i, int_req_o;
    oie_vec_t   set_data_i, clr_data_i, flag_i, int_en_o, en_m;
    logic [8:0] notes[$];
    logic [8:0] note;
    int         mismatches, checks, cyc, i;
    int unsigned seed_v;

    oie_bank oie_bank_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .set_wr_i(set_wr_i), .set_data_i(set_data_i),
                         .clr_wr_i(clr_wr_i), .clr_data_i(clr_data_i), .flag_i(flag_i),
                         .int_en_o(int_en_o), .int_req_o(int_req_o));

    // ****************************************************************
    // clock, cycle limit and verdict
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            stop_test();
        end
    end

    // ****************************************************************
    // driver: one cycle of inputs, note of the outputs one edge later
    // ****************************************************************
    task automatic step(input logic sw, input oie_vec_t sd, input logic cw, input oie_vec_t cd,
                        input oie_vec_t fl);
        logic req_m;
        @(posedge clk_i);
        set_wr_i   <= sw;
        set_data_i <= sd;
        clr_wr_i   <= cw;
        clr_data_i <= cd;
        flag_i     <= fl;
        req_m = |(en_m & fl);
        en_m  = ((en_m & ~(cw ? cd : 8'h00)) | (sw ? sd : 8'h00)) & `OIE_IMPL_MASK;
        @(negedge clk_i);
        notes.push_back({req_m, en_m});
    endtask : step

    // monitor: settled outputs against the oldest note
    always @(posedge clk_i) begin
        #1;
        if (notes.size() > 0) begin
            note = notes.pop_front();
            checks++;
            if ({int_req_o, int_en_o} !== note) begin
                mismatches++;
                $display("BAD t=%0t got=%h exp=%h", $time, {int_req_o, int_en_o}, note);
            end
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_b_i    = 1'b0;
        set_wr_i   = 1'b0;
        clr_wr_i   = 1'b0;
        set_data_i = 8'h00;
        clr_data_i = 8'h00;
        flag_i     = 8'h00;
        en_m       = 8'h00;
        mismatches = 0;
        checks     = 0;
        cyc        = 0;
        seed_v     = $urandom(32'hA66C5B94);
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) step(1'b0, 8'h00, 1'b0, 8'h00, 8'h00);
        // each source alone: set, request, zero-write, clear
        for (i = 1; i < 8; i++) begin
            step(1'b0, 8'h00, 1'b0, 8'h00, 8'h01 << i);
            step(1'b1, 8'h01 << i, 1'b0, 8'h00, 8'h01 << i);
            step(1'b1, 8'h00, 1'b0, 8'h00, 8'h01 << i);
            step(1'b0, 8'h00, 1'b1, 8'h01 << i, 8'h01 << i);
            step(1'b0, 8'h00, 1'b0, 8'h00, 8'h01 << i);
        end
        step(1'b1, 8'h01, 1'b0, 8'h00, 8'h01);
        step(1'b1, 8'hFF, 1'b1, 8'hFF, 8'hFF);
        step(1'b0, 8'h00, 1'b0, 8'h00, 8'h00);
        // mid-run reset: live enables and request drop, then restart cleanly
        step(1'b1, 8'hFE, 1'b0, 8'h00, 8'hFF);
        step(1'b0, 8'h00, 1'b0, 8'h00, 8'hFF);
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b0;
        @(negedge clk_i);
        en_m = 8'h00;
        notes.push_back(9'h000);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) step(1'b0, 8'h00, 1'b0, 8'h00, 8'h00);
        // random traffic on every strobe, data and flag input; reset stays released
        repeat (300) step(1'($urandom), 8'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
        repeat (2) @(posedge clk_i);
        #2;
        stop_test();
    end

endmodule : test_oie_bank

/* File: verilog/oie_bank.sv */
// oie_bank.sv - interrupt enable bank for the clock-source status flags of
// the oscillator and frequency-locked-loop controller.
// assumes: single bus clock; write strobes, data and status flags come from
// logic on that clock; reset arrives asynchronously and is released here.
//
// Operation
// - writing zero to any enable-set bit leaves that enable unchanged
// - writing one to lock-coarse bit sets the lock-coarse enable
// - bit 6 sets lock-fine enable; enabled flag raises interrupt request
// - bit 5 sets out-of-bounds enable; enabled flag raises interrupt request
// - bit 4 sets loop-ready enable; enabled flag raises interrupt request
// - bit 3 sets 8 MHz oscillator ready enable; enabled flag requests interrupt
// - bit 2 sets internal 32k ready enable; enabled flag requests interrupt
// - bit 1 sets external 32k crystal ready enable; enabled flag requests interrupt
// - reading an enable bit returns one when enabled, zero when disabled
`timescale 1ns/1ps
`include "oie_cfg.svh"

module oie_bank (
    input  wire logic              clk_i,       // bus clock, 100 MHz
    input  wire logic              rst_b_i,     // asynchronous reset, active low
    input  wire logic              set_wr_i,    // write strobe of the enable-set word
    input  wire oie_pkg::oie_vec_t set_data_i,  // enable-set data, ones set
    input  wire logic              clr_wr_i,    // write strobe of the enable-clear word
    input  wire oie_pkg::oie_vec_t clr_data_i,  // enable-clear data, ones clear
    input  wire oie_pkg::oie_vec_t flag_i,      // status flags of the sources
    output oie_pkg::oie_vec_t      int_en_o,    // enable readback
    output logic                   int_req_o    // interrupt request
);
    import oie_pkg::*;

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_reg;
    logic rst_sync_reg;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // strobe decode
    // ****************************************************************
    oie_vec_t set_vec;
    oie_vec_t clr_vec;
    oie_vec_t en_vec;
    oie_vec_t hit_vec;
    logic     req_next;
    logic     req_reg;

    // only ones written to implemented bits act; a zero, or any value on the
    // reserved bit 0, leaves the matching enable alone
    assign set_vec = set_wr_i ? (set_data_i & `OIE_IMPL_MASK) : `OIE_RESET_VAL;
    assign clr_vec = clr_wr_i ? (clr_data_i & `OIE_IMPL_MASK) : `OIE_RESET_VAL;

    // ****************************************************************
    // enable cells
    // ****************************************************************
    // one cell per implemented bit; reserved bit 0 reads zero
    assign en_vec[0]  = 1'b0;
    assign hit_vec[0] = 1'b0;
    for (genvar g = 1; g < `OIE_WIDTH; g++) begin : g_cell
        oie_en_cell u_cell (
            .clk_i   (clk_i),
            .rst_b_i (rst_sync_reg),
            .set_i   (set_vec[g]),
            .clr_i   (clr_vec[g]),
            .flag_i  (flag_i[g]),
            .en_o    (en_vec[g]),
            .hit_o   (hit_vec[g])
        );
    end

    // ****************************************************************
    // interrupt request and readback
    // ****************************************************************
    // any enabled flag requests an interrupt; the request is registered so the
    // output comes from a flip-flop, which costs one cycle of latency but keeps
    // glitches of the flag logic off the interrupt line
    assign req_next = |hit_vec;

    // request register
    always_ff @(posedge clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            req_reg <= 1'b0;
        end else begin
            req_reg <= req_next;
        end
    end

    assign int_req_o = req_reg;
    assign int_en_o  = en_vec;

    // ****************************************************************
    // assertions
    // ****************************************************************
    // every property below samples on the bus clock and is quiet while the
    // released reset is low; a mid-run reset aborts attempts in flight, so no
    // property needs to reason about the cycle in which reset falls
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_sync_reg);

    sequence s_set(int b);
        set_wr_i && set_data_i[b];
    endsequence

    sequence s_hit(int b);
        int_en_o[b] && flag_i[b];
    endsequence

    property p_zero_keeps;
        (set_wr_i && !clr_wr_i) |=> ((int_en_o & ~$past(set_data_i)) == ($past(int_en_o) & ~$past(set_data_i)));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed an enable");

    property p_set_bit(int b);
        s_set(b) |=> int_en_o[b];
    endproperty
    a_set_coarse: assert property (p_set_bit(`OIE_BIT_LOCK_COARSE)) else $error("lock coarse not set");
    a_set_fine: assert property (p_set_bit(`OIE_BIT_LOCK_FINE)) else $error("lock fine not set");
    a_set_oob: assert property (p_set_bit(`OIE_BIT_OUT_OF_BNDS)) else $error("out of bounds not set");
    a_set_ready: assert property (p_set_bit(`OIE_BIT_LOOP_READY)) else $error("loop ready not set");
    a_set_8mhz: assert property (p_set_bit(`OIE_BIT_OSC_8MHZ)) else $error("8 MHz ready not set");
    a_set_int32k: assert property (p_set_bit(`OIE_BIT_OSC_INT32K)) else $error("int 32k ready not set");
    a_set_xtal: assert property (p_set_bit(`OIE_BIT_XTAL_32K)) else $error("xtal 32k ready not set");

    property p_hit_raises(int b);
        s_hit(b) |=> int_req_o;
    endproperty
    a_hit_fine: assert property (p_hit_raises(`OIE_BIT_LOCK_FINE)) else $error("lock fine request missing");
    a_hit_xtal: assert property (p_hit_raises(`OIE_BIT_XTAL_32K)) else $error("xtal request missing");
    a_hit_coarse: assert property (p_hit_raises(`OIE_BIT_LOCK_COARSE)) else $error("coarse request missing");
    a_hit_oob: assert property (p_hit_raises(`OIE_BIT_OUT_OF_BNDS)) else $error("oob request missing");
    a_hit_ready: assert property (p_hit_raises(`OIE_BIT_LOOP_READY)) else $error("ready request missing");
    a_hit_8mhz: assert property (p_hit_raises(`OIE_BIT_OSC_8MHZ)) else $error("8 MHz request missing");
    a_hit_int32k: assert property (p_hit_raises(`OIE_BIT_OSC_INT32K)) else $error("int 32k request missing");

    property p_no_hit_low;
        ((int_en_o & flag_i) == `OIE_RESET_VAL) |=> !int_req_o;
    endproperty
    a_no_hit_low: assert property (p_no_hit_low) else $error("request without enabled flag");

    property p_read_holds;
        (!set_wr_i && !clr_wr_i) [*2] |-> $stable(int_en_o);
    endproperty
    a_read_holds: assert property (p_read_holds) else $error("enable readback drifted");

    property p_reserved_zero;
        int_en_o[0] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit not zero");

    // ****************************************************************
    // assertions over several steps
    // ****************************************************************
    // a set write, then the flag of that source, raises the request
    sequence s_set_then_flag(int b);
        s_set(b) ##1 flag_i[b];
    endsequence

    property p_set_flag_req(int b);
        s_set_then_flag(b) |=> int_req_o;
    endproperty
    a_path_coarse: assert property (p_set_flag_req(`OIE_BIT_LOCK_COARSE)) else $error("coarse path dead");
    a_path_fine: assert property (p_set_flag_req(`OIE_BIT_LOCK_FINE)) else $error("lock fine path dead");
    a_path_oob: assert property (p_set_flag_req(`OIE_BIT_OUT_OF_BNDS)) else $error("oob path dead");
    a_path_ready: assert property (p_set_flag_req(`OIE_BIT_LOOP_READY)) else $error("ready path dead");
    a_path_8mhz: assert property (p_set_flag_req(`OIE_BIT_OSC_8MHZ)) else $error("8 MHz path dead");
    a_path_int32k: assert property (p_set_flag_req(`OIE_BIT_OSC_INT32K)) else $error("int 32k path dead");
    a_path_xtal: assert property (p_set_flag_req(`OIE_BIT_XTAL_32K)) else $error("xtal path dead");

    // a clear without a set of the same bit turns that enable off
    sequence s_clr_only(int b);
        clr_wr_i && clr_data_i[b] && !(set_wr_i && set_data_i[b]);
    endsequence

    property p_clr_bit(int b);
        s_clr_only(b) |=> !int_en_o[b];
    endproperty
    a_clr_coarse: assert property (p_clr_bit(`OIE_BIT_LOCK_COARSE)) else $error("coarse not cleared");
    a_clr_fine: assert property (p_clr_bit(`OIE_BIT_LOCK_FINE)) else $error("lock fine not cleared");
    a_clr_oob: assert property (p_clr_bit(`OIE_BIT_OUT_OF_BNDS)) else $error("oob not cleared");
    a_clr_ready: assert property (p_clr_bit(`OIE_BIT_LOOP_READY)) else $error("ready not cleared");
    a_clr_8mhz: assert property (p_clr_bit(`OIE_BIT_OSC_8MHZ)) else $error("8 MHz not cleared");
    a_clr_int32k: assert property (p_clr_bit(`OIE_BIT_OSC_INT32K)) else $error("int 32k not cleared");
    a_clr_xtal: assert property (p_clr_bit(`OIE_BIT_XTAL_32K)) else $error("xtal not cleared");

    // the request is the enabled flags of the cycle before, no more, no less
    property p_req_follows;
        1'b1 |=> (int_req_o == $past(|(int_en_o & flag_i)));
    endproperty
    a_req_follows: assert property (p_req_follows) else $error("request not one cycle behind");

    // an enable drops only through a clear strobe of its own bit
    property p_drop_needs_clear;
        1'b1 |=> ((($past(int_en_o) & ~int_en_o) & ~$past(clr_vec)) == `OIE_RESET_VAL);
    endproperty
    a_drop_needs_clear: assert property (p_drop_needs_clear) else $error("enable dropped without clear");

    // an enable rises only through a set strobe of its own bit
    property p_rise_needs_set;
        1'b1 |=> (((~$past(int_en_o) & int_en_o) & ~$past(set_vec)) == `OIE_RESET_VAL);
    endproperty
    a_rise_needs_set: assert property (p_rise_needs_set) else $error("enable rose without set");

    // a write of zeros alone leaves the whole readback as it was
    sequence s_zero_set;
        set_wr_i && (set_data_i == `OIE_RESET_VAL) && !clr_wr_i;
    endsequence

    property p_zero_write_idle;
        s_zero_set |=> $stable(int_en_o);
    endproperty
    a_zero_write_idle: assert property (p_zero_write_idle) else $error("zero write moved an enable");

    // with every flag low the request drops one cycle later
    property p_req_low_without_flags;
        (flag_i == `OIE_RESET_VAL) |=> !int_req_o;
    endproperty
    a_req_low_without_flags: assert property (p_req_low_without_flags) else $error("request without flags");

endmodule : oie_bank

/* File: verilog/oie_cfg.svh */
// oie_cfg.svh - bit positions, reset values and masks of the oscillator
// interrupt enable bank.
// assumes: included by bare name by the package, the bank module and the bench.
`ifndef OIE_CFG_SVH
`define OIE_CFG_SVH

// ****************************************************************
// bit positions of the enable bits
// ****************************************************************
`define OIE_BIT_LOCK_COARSE  7
`define OIE_BIT_LOCK_FINE    6
`define OIE_BIT_OUT_OF_BNDS  5
`define OIE_BIT_LOOP_READY   4
`define OIE_BIT_OSC_8MHZ     3
`define OIE_BIT_OSC_INT32K   2
`define OIE_BIT_XTAL_32K     1

// ****************************************************************
// widths, reset value and implemented-bit mask
// ****************************************************************
`define OIE_WIDTH            8
`define OIE_RESET_VAL        8'h00
`define OIE_IMPL_MASK        8'hFE

`endif

/* File: verilog/oie_en_cell.sv */
// oie_en_cell.sv - one interrupt enable bit with set and clear strobes and
// its gated request term.
// assumes: clock and reset already synchronised by the caller; strobes and
// flag come from logic on the same clock.
`timescale 1ns/1ps

module oie_en_cell (
    input  wire logic clk_i,     // bus clock
    input  wire logic rst_b_i,   // synchronised reset, active low
    input  wire logic set_i,     // write-one-to-set strobe for this bit
    input  wire logic clr_i,     // write-one-to-clear strobe for this bit
    input  wire logic flag_i,    // status flag of this source
    output logic      en_o,      // enable state, from a flip-flop
    output logic      hit_o      // flag gated by enable
);

    logic en_reg;
    logic en_next;

    // set wins over a clear in the same cycle; no strobe holds the bit
    assign en_next = set_i ? 1'b1 : (clr_i ? 1'b0 : en_reg);

    // enable storage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
        end
    end

    assign en_o  = en_reg;
    assign hit_o = en_reg & flag_i;

endmodule : oie_en_cell

/* File: verilog/oie_pkg.sv */
// oie_pkg.sv - types shared by the oscillator interrupt enable bank.
// assumes: oie_cfg.svh is on the include path.
`include "oie_cfg.svh"

package oie_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [`OIE_WIDTH-1:0] oie_vec_t;   // one bit per interrupt source

endpackage : oie_pkg
